/* File: mrr_sequencer.v */
// Main converter round robin sequencer with byte-wide result registers.
// Assumes an external SAR core that takes a slot select and returns a sample pulse.
`timescale 1ns/100ps
`include "mrr_defs.vh"
// Function
// - Twenty-four slots measured in repeating round robin
// - Eight microseconds per slot, 192 per pass; slots here take 1001 clocks (8.008 us), 24024 per pass
// - Slots: die, reference, sixteen channels, current, gp, then four spare slots whose samples are not stored
// - One general input per pass, rotating
// - 16-bit two's-complement results as byte pairs
// - Enable presets all results to 0x8000
// - Result pair updates when its slot completes
// - High read freezes low until low read
// - Start delay aligns chained devices
// - Channel results pass a lowpass filter
// - Main and aux converters enabled separately
// - Fault status in frames, optional fault pin
// - Active runs all; sleep, shutdown stop converter
// - Hardware reset equals power-on reset
// - Go latches settings; resend to change
// - Unconfigured gp slot skipped, stays 0x8000
// - Data ready after eight passes; running bit
module mrr_sequencer #(
  parameter DELAY_UNIT_CYC = 125
) (
  input wire clk,
  input wire nrst,
  input wire hw_reset_req,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  output wire irq,
  output reg [4:0] conv_slot,
  output reg [2:0] conv_gp_sel,
  output reg conv_start,
  input wire conv_done,
  input wire [15:0] conv_data,
  output reg aux_enable,
  output reg fault_pin_active_low,
  output reg frame_fault_flag,
  output reg main_run,
  output reg main_converter_data_ready
);

  // ----------------------------------------
  // Reset release
  // ----------------------------------------
  reg rst_s1_r;
  reg rst_s2_r;
  wire rst_n;

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_s1_r <= 1'b0;
      rst_s2_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_s2_r <= 1'b1;
    end
  end

  // Hardware reset request acts like power-on reset
  wire hw_rst_req_sync;
  reg hwr_s1_r;
  reg hwr_s2_r;
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      hwr_s1_r <= 1'b0;
      hwr_s2_r <= 1'b0;
    end else begin
      hwr_s1_r <= hw_reset_req;
      hwr_s2_r <= hwr_s1_r;
    end
  end
  assign hw_rst_req_sync = hwr_s2_r;
  assign rst_n = rst_s2_r & ~hw_rst_req_sync;

  // ----------------------------------------
  // Converter sample synchroniser
  // ----------------------------------------
  reg done_s1_r;
  reg done_s2_r;
  reg done_s3_r;
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      done_s1_r <= 1'b0;
      done_s2_r <= 1'b0;
      done_s3_r <= 1'b0;
    end else begin
      done_s1_r <= conv_done;
      done_s2_r <= done_s1_r;
      done_s3_r <= done_s2_r;
    end
  end

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  reg [7:0] delay_cfg_r;
  reg [7:0] gp_cfg_r;
  reg [7:0] filt_cfg_r;
  reg [1:0] pwr_mode_r;
  reg fault_pin_en_r;
  reg frame_fault_en_r;
  reg [7:0] delay_lat_r;
  reg [7:0] gp_lat_r;
  reg [1:0] filt_lat_r;
  reg [2:0] irq_stat_r;
  reg [2:0] irq_en_r;

  wire wr_ctrl = reg_wr && (reg_addr == `MRR_ADDR_CTRL);
  wire go_cmd = wr_ctrl && reg_wdata[`MRR_CTRL_GO];
  wire stop_cmd = (wr_ctrl && reg_wdata[`MRR_CTRL_STOP]) ||
    (pwr_mode_r != `MRR_MODE_ACTIVE);

  // ----------------------------------------
  // Sequencer state machine
  // ----------------------------------------
  localparam ST_IDLE = 4'b0001;
  localparam ST_DELAY = 4'b0010;
  localparam ST_CONV = 4'b0100;
  localparam ST_WAIT = 4'b1000;

  reg [3:0] state_r;
  reg [15:0] tmr_r;
  reg [4:0] slot_r;
  reg [2:0] gp_idx_r;
  reg [3:0] pass_cnt_r;
  reg pass_evt;
  reg align_evt;

  function gp_active;
    input [7:0] cfg;
    input [2:0] idx;
    begin
      gp_active = cfg[idx];
    end
  endfunction

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
      tmr_r <= 16'h0000;
      slot_r <= 5'h00;
      gp_idx_r <= 3'h0;
      pass_cnt_r <= 4'h0;
      main_run <= 1'b0;
      main_converter_data_ready <= 1'b0;
      conv_slot <= 5'h00;
      conv_gp_sel <= 3'h0;
      conv_start <= 1'b0;
      delay_lat_r <= 8'h00;
      gp_lat_r <= 8'h00;
      filt_lat_r <= 2'h0;
      pass_evt <= 1'b0;
      align_evt <= 1'b0;
    end else begin
      conv_start <= 1'b0;
      pass_evt <= 1'b0;
      align_evt <= 1'b0;
      if (go_cmd && !stop_cmd) begin
        delay_lat_r <= delay_cfg_r;
        gp_lat_r <= gp_cfg_r;
        filt_lat_r <= filt_cfg_r[1:0];
        state_r <= ST_DELAY;
        tmr_r <= 16'h0000;
        slot_r <= `MRR_SLOT_DIE;
        gp_idx_r <= 3'h0;
        pass_cnt_r <= 4'h0;
        main_converter_data_ready <= 1'b0;
        main_run <= 1'b1;
      end else if (stop_cmd) begin
        state_r <= ST_IDLE;
        main_run <= 1'b0;
      end else begin
        case (state_r)
          ST_IDLE: begin
            state_r <= ST_IDLE;
          end
          ST_DELAY: begin
            // Start delay lets a chain sample all channels together
            if (tmr_r >= delay_lat_r * DELAY_UNIT_CYC) begin
              state_r <= ST_CONV;
              tmr_r <= 16'h0000;
              align_evt <= 1'b1;
            end else begin
              tmr_r <= tmr_r + 16'h0001;
            end
          end
          ST_CONV: begin
            conv_slot <= slot_r;
            conv_gp_sel <= gp_idx_r;
            // Inactive gp input keeps its turn but is not sampled
            conv_start <= (slot_r != `MRR_SLOT_GP) ||
              gp_active(gp_lat_r, gp_idx_r);
            tmr_r <= 16'h0001;
            state_r <= ST_WAIT;
          end
          ST_WAIT: begin
            if (tmr_r == `MRR_SLOT_CYC) begin
              tmr_r <= 16'h0000;
              state_r <= ST_CONV;
              if (slot_r == `MRR_NSLOTS - 1) begin
                slot_r <= 5'h00;
                gp_idx_r <= gp_idx_r + 3'h1;
                pass_evt <= 1'b1;
                if (pass_cnt_r != `MRR_DRDY_PASSES)
                  pass_cnt_r <= pass_cnt_r + 4'h1;
                if (pass_cnt_r == `MRR_DRDY_PASSES - 1)
                  main_converter_data_ready <= 1'b1;
              end else begin
                slot_r <= slot_r + 5'h01;
              end
            end else begin
              tmr_r <= tmr_r + 16'h0001;
            end
          end
          default: state_r <= ST_IDLE;
        endcase
      end
    end
  end

  // ----------------------------------------
  // Result storage
  // ----------------------------------------
  reg [15:0] res_r [0:`MRR_NRESULT-1];
  reg [7:0] low_shadow_r [0:`MRR_NRESULT-1];
  reg [`MRR_NRESULT-1:0] low_hold_r;
  reg [15:0] filt_in;
  reg [5:0] res_idx;
  reg res_filtered;

  // Sample lands on the slot still presented to the converter
  always @* begin
    res_filtered = 1'b0;
    if (conv_slot == `MRR_SLOT_GP)
      res_idx = `MRR_IDX_GP1 + {3'h0, conv_gp_sel};
    else
      res_idx = {1'b0, conv_slot};
    if (conv_slot >= `MRR_SLOT_VS1 && conv_slot <= `MRR_SLOT_CUR)
      res_filtered = (filt_lat_r != 2'h0);
  end

  // Single pole filter, coefficient 1/2^(k+1) selected at go
  function [15:0] post_conversion_lowpass;
    input [15:0] prev;
    input [15:0] smp;
    input [1:0] k;
    reg signed [16:0] diff;
    reg signed [16:0] step;
    begin
      diff = $signed({smp[15], smp}) - $signed({prev[15], prev});
      step = diff >>> ({2'h0, k} + 3'h1);
      post_conversion_lowpass = prev + step[15:0];
    end
  endfunction

  wire sample_rx = done_s2_r & ~done_s3_r;
  wire is_spare = (conv_slot > `MRR_SLOT_GP);
  wire hi_rd = reg_rd && (reg_addr < 2 * `MRR_NRESULT) && !reg_addr[0];
  wire lo_rd = reg_rd && (reg_addr < 2 * `MRR_NRESULT) && reg_addr[0];
  wire [5:0] rd_idx = reg_addr[6:1];
  integer i;

  always @(posedge clk) begin
    if (go_cmd) begin
      for (i = 0; i < `MRR_NRESULT; i = i + 1) begin
        res_r[i] <= `MRR_RESULT_DEFAULT;
        // Low byte of the 0x8000 default
        low_shadow_r[i] <= 8'h00;
      end
    end else if (sample_rx && main_run && !is_spare) begin
      // Filter seeds from the first sample after a go
      if (res_filtered && res_r[res_idx] != `MRR_RESULT_DEFAULT)
        res_r[res_idx] <= post_conversion_lowpass(res_r[res_idx], conv_data, filt_lat_r - 2'h1);
      else
        res_r[res_idx] <= conv_data;
    end
    // Shadow is only read while held, so capture at the high read suffices
    if (hi_rd && !low_hold_r[rd_idx])
      low_shadow_r[rd_idx] <= res_r[rd_idx][7:0];
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      low_hold_r <= {`MRR_NRESULT{1'b0}};
    end else begin
      if (go_cmd)
        low_hold_r <= {`MRR_NRESULT{1'b0}};
      else if (hi_rd)
        low_hold_r[rd_idx] <= 1'b1;
      else if (lo_rd)
        low_hold_r[rd_idx] <= 1'b0;
    end
  end

  // ----------------------------------------
  // Register writes and interrupts
  // ----------------------------------------
  wire [2:0] irq_evt = {align_evt, main_converter_data_ready & pass_evt &
    (pass_cnt_r == `MRR_DRDY_PASSES), pass_evt};
  wire [2:0] irq_clr = (reg_wr && reg_addr == `MRR_ADDR_IRQ_CLR) ? reg_wdata[2:0] : 3'h0;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      delay_cfg_r <= 8'h00;
      gp_cfg_r <= 8'h00;
      filt_cfg_r <= 8'h00;
      pwr_mode_r <= `MRR_MODE_ACTIVE;
      aux_enable <= 1'b0;
      fault_pin_en_r <= 1'b0;
      frame_fault_en_r <= 1'b0;
      irq_stat_r <= 3'h0;
      irq_en_r <= 3'h0;
    end else begin
      if (wr_ctrl) begin
        aux_enable <= reg_wdata[`MRR_CTRL_AUX_EN];
        fault_pin_en_r <= reg_wdata[`MRR_CTRL_FAULT_PIN_EN];
        frame_fault_en_r <= reg_wdata[`MRR_CTRL_FRAME_FAULT_EN];
      end
      if (reg_wr && reg_addr == `MRR_ADDR_DELAY)
        delay_cfg_r <= reg_wdata;
      if (reg_wr && reg_addr == `MRR_ADDR_GPCFG)
        gp_cfg_r <= reg_wdata;
      if (reg_wr && reg_addr == `MRR_ADDR_FILT)
        filt_cfg_r <= reg_wdata;
      if (reg_wr && reg_addr == `MRR_ADDR_MODE)
        pwr_mode_r <= reg_wdata[1:0];
      if (reg_wr && reg_addr == `MRR_ADDR_IRQ_EN)
        irq_en_r <= reg_wdata[2:0];
      // Set wins over a clear in the same cycle
      irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_evt;
    end
  end

  assign irq = |(irq_stat_r & irq_en_r);

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fault_pin_active_low <= 1'b1;
      frame_fault_flag <= 1'b0;
    end else begin
      fault_pin_active_low <= ~(fault_pin_en_r & irq);
      frame_fault_flag <= frame_fault_en_r & irq;
    end
  end

  // ----------------------------------------
  // Read data, one cycle after the strobe
  // ----------------------------------------
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      if (hi_rd)
        reg_rdata <= res_r[rd_idx][15:8];
      else if (lo_rd)
        reg_rdata <= low_hold_r[rd_idx] ? low_shadow_r[rd_idx] : res_r[rd_idx][7:0];
      else begin
        case (reg_addr)
          `MRR_ADDR_DELAY: reg_rdata <= delay_cfg_r;
          `MRR_ADDR_GPCFG: reg_rdata <= gp_cfg_r;
          `MRR_ADDR_FILT: reg_rdata <= filt_cfg_r;
          `MRR_ADDR_MODE: reg_rdata <= {6'h00, pwr_mode_r};
          `MRR_ADDR_STAT: reg_rdata <= {3'h0, pass_cnt_r[3:0] == 4'h8,
            aux_enable, 1'b0, main_converter_data_ready, main_run};
          `MRR_ADDR_IRQ_STAT: reg_rdata <= {5'h00, irq_stat_r};
          `MRR_ADDR_IRQ_EN: reg_rdata <= {5'h00, irq_en_r};
          default: reg_rdata <= 8'h00;
        endcase
      end
    end else begin
      reg_rdata <= 8'h00;
    end
  end

endmodule // mrr_sequencer

/* File: mrr_defs.vh */
// Constants for the main converter round robin sequencer.
// Assumes a 125 MHz system clock and a byte-wide register port.
`ifndef MRR_DEFS_VH
`define MRR_DEFS_VH
// ----------------------------------------
// Timing
// ----------------------------------------
`define MRR_CLK_MHZ 125
`define MRR_SLOT_US 8
`define MRR_SLOT_CYC (`MRR_SLOT_US * `MRR_CLK_MHZ)
`define MRR_PASS_US 192
`define MRR_ALIGN_US 128
`define MRR_NSLOTS 24
`define MRR_NGP 8
`define MRR_NRESULT 33
`define MRR_DRDY_PASSES 8
// ----------------------------------------
// Slot order
// ----------------------------------------
`define MRR_SLOT_DIE 5'h00
`define MRR_SLOT_TREF 5'h01
`define MRR_SLOT_VS1 5'h02
`define MRR_SLOT_CUR 5'h12
`define MRR_SLOT_GP 5'h13
// ----------------------------------------
// Result index: die, tref, vs1..16, cur, gp1..8
// ----------------------------------------
`define MRR_IDX_CUR 6'h12
`define MRR_IDX_GP1 6'h13
`define MRR_RESULT_DEFAULT 16'h8000
// ----------------------------------------
// Register map (byte addresses)
// ----------------------------------------
`define MRR_ADDR_RES_BASE 8'h00
`define MRR_ADDR_CTRL 8'h50
`define MRR_ADDR_DELAY 8'h51
`define MRR_ADDR_GPCFG 8'h52
`define MRR_ADDR_FILT 8'h53
`define MRR_ADDR_STAT 8'h54
`define MRR_ADDR_IRQ_STAT 8'h55
`define MRR_ADDR_IRQ_EN 8'h56
`define MRR_ADDR_IRQ_CLR 8'h57
`define MRR_ADDR_MODE 8'h58
`define MRR_CTRL_GO 0
`define MRR_CTRL_STOP 1
`define MRR_CTRL_AUX_EN 2
`define MRR_CTRL_FAULT_PIN_EN 3
`define MRR_CTRL_FRAME_FAULT_EN 4
`define MRR_IRQ_PASS 0
`define MRR_IRQ_DRDY 1
`define MRR_IRQ_ALIGN 2
`define MRR_MODE_ACTIVE 2'h0
`define MRR_MODE_SLEEP 2'h1
`define MRR_MODE_SHUTDOWN 2'h2
`endif

/* File: mrr_checker_assertions.sv */
// Port checker for the main converter round robin sequencer.
// Assumes one clock domain; nrst low clears every helper register.
`timescale 1ns/100ps
module mrr_checker (
  input wire clk,
  input wire nrst,
  input wire hw_reset_req,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_rdata,
  input wire irq,
  input wire [4:0] conv_slot,
  input wire [2:0] conv_gp_sel,
  input wire conv_start,
  input wire conv_done,
  input wire [15:0] conv_data,
  input wire aux_enable,
  input wire fault_pin_active_low,
  input wire frame_fault_flag,
  input wire main_run,
  input wire main_converter_data_ready
);
  reg [11:0] gap_r;
  reg [8:0] starts_r;
  reg [4:0] last_r;
  reg seen_r;
  wire [4:0] nxt = (last_r == 5'h17) ? 5'h00 : last_r + 5'h01;
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      gap_r <= 12'h000;
      starts_r <= 9'h000;
      last_r <= 5'h00;
      seen_r <= 1'b0;
    end else begin
      gap_r <= conv_start ? 12'h000 : ((gap_r == 12'hfff) ? gap_r : gap_r + 12'h001);
      starts_r <= !main_run ? 9'h000 :
        ((conv_start && starts_r != 9'h1ff) ? starts_r + 9'h001 : starts_r);
      last_r <= conv_start ? conv_slot : last_r;
      seen_r <= main_run && (seen_r || conv_start);
    end
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  property p_rdata_idle; !$past(reg_rd) |-> reg_rdata == 8'h00; endproperty
  property p_slot; conv_start |-> conv_slot < 5'h18 && main_run; endproperty
  property p_pulse; conv_start |=> !conv_start; endproperty
  property p_gap; conv_start && seen_r |-> gap_r == 12'd1000 || gap_r == 12'd2001; endproperty
  property p_order; conv_start && seen_r |-> conv_slot == nxt || (nxt == 5'h13 && conv_slot == 5'h14);
  endproperty
  property p_fault; $fell(fault_pin_active_low) |-> $past(irq); endproperty
  property p_frame; $rose(frame_fault_flag) |-> $past(irq); endproperty
  property p_drdy; $rose(main_converter_data_ready) |-> main_run && starts_r >= 9'd184; endproperty
  property p_hwrst; $rose(hw_reset_req) |-> ##[1:6] !main_run; endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read slot");
  a_slot: assert property (p_slot) else $error("slot start out of range");
  a_pulse: assert property (p_pulse) else $error("slot start not one cycle");
  a_gap: assert property (p_gap) else $error("slot spacing wrong");
  a_order: assert property (p_order) else $error("slot order wrong");
  a_fault: assert property (p_fault) else $error("fault pin without interrupt");
  a_frame: assert property (p_frame) else $error("frame flag without interrupt");
  a_drdy: assert property (p_drdy) else $error("data ready too early");
  a_hwrst: assert property (p_hwrst) else $error("hardware reset left converter running");
  c_start: cover property (conv_start);
  c_run: cover property ($rose(main_run));
  c_irq: cover property ($rose(irq));
endmodule // mrr_checker

bind mrr_sequencer mrr_checker u_mrr_checker (.clk(clk), .nrst(nrst),
  .hw_reset_req(hw_reset_req), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq), .conv_slot(conv_slot),
  .conv_gp_sel(conv_gp_sel), .conv_start(conv_start), .conv_done(conv_done),
  .conv_data(conv_data), .aux_enable(aux_enable), .fault_pin_active_low(fault_pin_active_low),
  .frame_fault_flag(frame_fault_flag), .main_run(main_run),
  .main_converter_data_ready(main_converter_data_ready));

/* File: mrr_conv_model.sv */
// Behavioural converter core answering each slot start.
// Assumes conv_start is a one-cycle pulse; odd slots answer slowly.
`timescale 1ns/100ps
module mrr_conv_model (
  input wire clk,
  input wire conv_start,
  input wire [4:0] conv_slot,
  output reg conv_done,
  output reg [15:0] conv_data
);
  reg [9:0] cnt;
  reg [9:0] lat;
  reg act;
  initial begin
    conv_done = 1'b0;
    conv_data = 16'h5a5a;
    act = 1'b0;
  end
  always @(posedge clk) begin
    if (conv_start) begin
      cnt <= 10'h000;
      lat <= conv_slot[0] ? 10'h258 : 10'h014;
      act <= 1'b1;
      conv_data <= {3'h5, conv_slot, 3'h2, conv_slot};
    end else if (act) begin
      cnt <= cnt + 10'h001;
      conv_done <= (cnt >= lat) && (cnt < lat + 10'h008);
      // Data is not held once the sample pulse has gone
      if (cnt == lat + 10'h008) begin
        act <= 1'b0;
        conv_data <= ~conv_data;
      end
    end
  end
endmodule // mrr_conv_model

/* File: main_adc_round_robin_sequencer_bench.sv */
// Self-checking bench for the round robin sequencer.
// Assumes the behavioural converter model and a 125 MHz clock.
`timescale 1ns/100ps
module main_adc_round_robin_sequencer_bench;
  reg clk = 1'b0;
  reg nrst = 1'b0;
  reg hw_reset_req = 1'b0;
  reg reg_wr = 1'b0;
  reg reg_rd = 1'b0;
  reg [7:0] reg_addr = 8'h00;
  reg [7:0] reg_wdata = 8'h00;
  wire [7:0] reg_rdata;
  wire [4:0] conv_slot;
  wire [15:0] conv_data;
  wire irq, conv_start, conv_done, aux_enable, fault_pin_active_low, frame_fault_flag, main_run;
  integer bad_count = 0;
  integer cmp_count = 0;
  integer i;
  integer n;
  reg [7:0] d;
  reg [15:0] e;
  always #4 clk = ~clk;
  mrr_sequencer #(.DELAY_UNIT_CYC(1)) u_mrr_sequencer (.clk(clk), .nrst(nrst),
    .hw_reset_req(hw_reset_req), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq), .conv_slot(conv_slot), .conv_gp_sel(),
    .conv_start(conv_start), .conv_done(conv_done), .conv_data(conv_data),
    .aux_enable(aux_enable), .fault_pin_active_low(fault_pin_active_low),
    .frame_fault_flag(frame_fault_flag), .main_run(main_run), .main_converter_data_ready());
  mrr_conv_model u_mrr_conv_model (.clk(clk), .conv_start(conv_start), .conv_slot(conv_slot),
    .conv_done(conv_done), .conv_data(conv_data));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task chk(input string nm, input [15:0] exp, input [15:0] got);
    begin
      cmp_count = cmp_count + 1;
      if (got !== exp) begin
        bad_count = bad_count + 1;
        $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      end
    end
  endtask
  task wr(input [7:0] a, input [7:0] v);
    begin
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
    end
  endtask
  task rd(input [7:0] a, output [7:0] v);
    begin
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 v = reg_rdata;
    end
  endtask
  task rc(input string nm, input [7:0] a, input [7:0] exp);
    begin
      rd(a, d);
      chk(nm, {8'h00, exp}, {8'h00, d});
    end
  endtask
  task stop_test;
    begin
      $display("Comparisons %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    rc("status", 8'h54, 8'h00);
    rc("unmapped", 8'h60, 8'h00);
    wr(8'h58, 8'h01);
    wr(8'h50, 8'h01);
    repeat (20) @(posedge clk);
    chk("run in sleep", 16'h0000, {15'h0000, main_run});
    wr(8'h58, 8'h00);
    wr(8'h52, 8'h00);
    wr(8'h53, 8'h00);
    wr(8'h51, 8'h00);
    wr(8'h50, 8'h05);
    repeat (4) @(posedge clk);
    chk("run", 16'h0001, {15'h0000, main_run});
    chk("aux", 16'h0001, {15'h0000, aux_enable});
    rc("ch1 high early", 8'h04, 8'h80);
    // Bounded poll for the end of the first pass
    d = 8'h00;
    for (n = 0; n < 2000 && d[0] !== 1'b1; n = n + 1) begin
      repeat (16) @(posedge clk);
      rd(8'h55, d);
    end
    chk("pass flag", 16'h0001, {15'h0000, d[0]});
    if (d[0] !== 1'b1)
      stop_test;
    chk("irq masked", 16'h0000, {15'h0000, irq});
    for (i = 0; i < 19; i = i + 1) begin
      e = {3'h5, i[4:0], 3'h2, i[4:0]};
      if (i == 2) begin
        rc("ch1 low held", 8'h05, 8'h00);
      end else begin
        rc("result high", {i[6:0], 1'b0}, e[15:8]);
        rc("result low", {i[6:0], 1'b1}, e[7:0]);
      end
    end
    for (i = 19; i < 27; i = i + 1) begin
      rc("gp high", {i[6:0], 1'b0}, 8'h80);
      rc("gp low", {i[6:0], 1'b1}, 8'h00);
    end
    rc("ch1 high", 8'h04, 8'ha2);
    wr(8'h56, 8'h01);
    @(posedge clk);
    #1 chk("irq on", 16'h0001, {15'h0000, irq});
    wr(8'h50, 8'h1c);
    repeat (2) @(posedge clk);
    #1 chk("fault pin", 16'h0000, {15'h0000, fault_pin_active_low});
    chk("frame flag", 16'h0001, {15'h0000, frame_fault_flag});
    wr(8'h57, 8'h01);
    @(posedge clk);
    #1 chk("irq cleared", 16'h0000, {15'h0000, irq});
    @(posedge clk);
    hw_reset_req <= 1'b1;
    repeat (6) @(posedge clk);
    hw_reset_req <= 1'b0;
    repeat (4) @(posedge clk);
    #1 chk("run after reset", 16'h0000, {15'h0000, main_run});
    chk("aux after reset", 16'h0000, {15'h0000, aux_enable});
    stop_test;
  end
endmodule // main_adc_round_robin_sequencer_bench
